// File: rtl/usb_host_intr_regs.sv
// Behaviour
// - one in clear register clears enable bit
// - zero bits in clear write change nothing
// - clear register reads back enable register
// - bit31 clears master gate, bit30 ownership
// - bits 6..0 clear the event enables
// - base register written by driver only
// - base bits 7..0 held at zero
// - periodic pointer updated by controller, read-only
// - periodic pointer bits 3..0 read zero
// - irq needs status, enable and master gate
// - enable register sets on one, ignores zero
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "usb_host_regs_defs.svh"
`default_nettype none

module usb_host_intr_regs
	import usb_host_regs_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// AXI4-Lite write address
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	// AXI4-Lite write data
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// AXI4-Lite write response
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// AXI4-Lite read address
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	// AXI4-Lite read data
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	// Controller side
	input  wire logic [31:0] intr_status,
	input  wire ptr_update_s ptr_update,
	output logic [31:0]      interrupt_enable_register,
	output logic [31:0]      shared_comm_area,
	output logic             irq
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	wr_state_e   wr_state_reg;      // Write path state
	wr_state_e   wr_state_next;     // Next write state
	logic        aw_held_reg;       // Address captured
	logic        w_held_reg;        // Data captured
	wr_req_s     wr_req_reg;        // Captured request
	logic [31:0] lane_mask;         // Byte enables as bit mask
	logic [31:0] wr_ones;           // Written ones under strobes
	logic        wr_exec;           // Register update cycle
	reg_sel_e    wr_sel;            // Target of the write
	reg_sel_e    rd_sel;            // Target of the read
	logic [1:0]  bresp_reg;         // Write response code
	logic        rvalid_reg;        // Read data pending
	logic [31:0] rdata_reg;         // Read data
	logic [1:0]  rresp_reg;         // Read response code
	logic [31:0] enable_reg;        // Interrupt enable bits
	logic [31:0] base_reg;          // Shared area base
	logic [31:0] ptr_reg;           // Periodic descriptor pointer
	logic        irq_reg;           // Registered request

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	// Maps a byte address to a register
	function automatic reg_sel_e decode(input logic [7:0] addr);
		case (addr)
			`OFS_INT_ENABLE:   decode = SEL_ENABLE;
			`OFS_INT_EN_CLEAR: decode = SEL_CLEAR;
			`OFS_SHARED_BASE:  decode = SEL_BASE;
			`OFS_PERIODIC_PTR: decode = SEL_PTR;
			default:           decode = SEL_NONE;
		endcase
	endfunction

	assign wr_sel = decode(wr_req_reg.addr);
	assign rd_sel = decode(s_axi_araddr);

	// Byte strobes widened to bit lanes
	genvar lane;
	generate
		for (lane = 0; lane < 4; lane++) begin : g_lane
			assign lane_mask[lane*8 +: 8] = {8{wr_req_reg.strb[lane]}};
		end
	endgenerate

	assign wr_ones = wr_req_reg.data & lane_mask;
	assign wr_exec = (wr_state_reg == WR_EXEC);

	// ------------------------------------------------------------
	// Write channels
	// ------------------------------------------------------------
	// Accept address and data in either order while waiting
	assign s_axi_awready = (wr_state_reg == WR_WAIT) && !aw_held_reg;
	assign s_axi_wready  = (wr_state_reg == WR_WAIT) && !w_held_reg;
	assign s_axi_bvalid  = (wr_state_reg == WR_RESP);
	assign s_axi_bresp   = bresp_reg;

	// Next write state
	always_comb begin
		wr_state_next = wr_state_reg;
		case (wr_state_reg)
			// Both halves present
			WR_WAIT: begin
				if (aw_held_reg && w_held_reg) begin
					wr_state_next = WR_EXEC;
				end
			end
			// Update happens in this cycle
			WR_EXEC: wr_state_next = WR_RESP;
			// Hold response until taken
			WR_RESP: begin
				if (s_axi_bready) begin
					wr_state_next = WR_WAIT;
				end
			end
			default: wr_state_next = WR_WAIT;
		endcase
	end

	// Write state register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wr_state_reg <= WR_WAIT;
		end else begin
			wr_state_reg <= wr_state_next;
		end
	end

	// Capture address half
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			aw_held_reg     <= 1'b0;
			wr_req_reg.addr <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_reg     <= 1'b1;
			wr_req_reg.addr <= s_axi_awaddr;
		end else if (wr_exec) begin
			aw_held_reg <= 1'b0;
		end
	end

	// Capture data half
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			w_held_reg      <= 1'b0;
			wr_req_reg.data <= 32'h00000000;
			wr_req_reg.strb <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_reg      <= 1'b1;
			wr_req_reg.data <= s_axi_wdata;
			wr_req_reg.strb <= s_axi_wstrb;
		end else if (wr_exec) begin
			w_held_reg <= 1'b0;
		end
	end

	// Response code: unmapped address is an error
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bresp_reg <= `RESP_OKAY;
		end else if (wr_exec) begin
			bresp_reg <= (wr_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
		end
	end

	// ------------------------------------------------------------
	// Read channels
	// ------------------------------------------------------------
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

	// Read data is sampled when the address is taken
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h00000000;
			rresp_reg  <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_reg <= 1'b1;
			rresp_reg  <= `RESP_OKAY;
			case (rd_sel)
				SEL_ENABLE: rdata_reg <= enable_reg;
				SEL_CLEAR:  rdata_reg <= enable_reg;
				SEL_BASE:   rdata_reg <= base_reg;
				SEL_PTR:    rdata_reg <= ptr_reg;
				// Unmapped reads zero with error
				default: begin
					rdata_reg <= 32'h00000000;
					rresp_reg <= `RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Interrupt enable register
	// ------------------------------------------------------------
	// Reserved bits are not stored and read zero
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			enable_reg <= `EN_RESET;
		end else if (wr_exec && wr_sel == SEL_ENABLE) begin
			enable_reg <= enable_reg | (wr_ones & `EN_DEFINED_MASK);
		end else if (wr_exec && wr_sel == SEL_CLEAR) begin
			enable_reg <= enable_reg & ~(wr_ones & `EN_DEFINED_MASK);
		end
	end

	assign interrupt_enable_register = enable_reg;

	// ------------------------------------------------------------
	// Shared area base and periodic pointer
	// ------------------------------------------------------------
	// Driver writes the base, low byte forced to zero
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			base_reg <= `BASE_RESET;
		end else if (wr_exec && wr_sel == SEL_BASE) begin
			base_reg <= ((base_reg & ~lane_mask) | wr_ones) & `BASE_ALIGN_MASK;
		end
	end

	assign shared_comm_area = base_reg;

	// Controller loads the pointer; bus writes are ignored
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ptr_reg <= `PTR_RESET;
		end else if (ptr_update.load) begin
			ptr_reg <= ptr_update.addr & `PTR_ALIGN_MASK;
		end
	end

	// ------------------------------------------------------------
	// Interrupt request
	// ------------------------------------------------------------
	// gate status by enables and master
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= enable_reg[`BIT_MASTER_GATE] &&
				|(intr_status & enable_reg & `EN_SOURCE_MASK);
		end
	end

	assign irq = irq_reg;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking dflt_cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	// Clear and set write cycles, and the read of the clear register
	sequence s_clear_wr;
		wr_exec && wr_sel == SEL_CLEAR;
	endsequence
	sequence s_set_wr;
		wr_exec && wr_sel == SEL_ENABLE;
	endsequence
	sequence s_read_clear;
		s_axi_arvalid && s_axi_arready && rd_sel == SEL_CLEAR;
	endsequence

	AST_CLR_ONE: assert property (s_clear_wr |=>
		(enable_reg & $past(wr_ones) & `EN_DEFINED_MASK) == 32'h00000000)
		else $error("enable bit survived a clear");
	AST_CLR_ZERO: assert property (s_clear_wr |=>
		(enable_reg & ~$past(wr_ones)) == ($past(enable_reg) & ~$past(wr_ones)))
		else $error("clear write changed an unselected bit");
	AST_RD_MIRROR: assert property (s_read_clear |=>
		s_axi_rvalid && s_axi_rdata == $past(enable_reg))
		else $error("clear register read differs from enables");
	AST_MASTER_CLR: assert property ((s_clear_wr ##0
		wr_ones[`BIT_MASTER_GATE]) |=> ##1 !irq)
		else $error("irq raised after master gate cleared");
	AST_RSVD_ZERO: assert property (
		(enable_reg & ~`EN_DEFINED_MASK) == 32'h00000000)
		else $error("reserved enable bit set");
	AST_BASE_WR: assert property ((wr_exec && wr_sel == SEL_BASE
		&& wr_req_reg.strb == 4'hf) |=>
		base_reg == ($past(wr_req_reg.data) & `BASE_ALIGN_MASK))
		else $error("base register not written");
	AST_BASE_LOW: assert property (base_reg[7:0] == 8'h00)
		else $error("base low byte not zero");
	AST_PTR_LOAD: assert property (ptr_update.load |=>
		ptr_reg == ($past(ptr_update.addr) & `PTR_ALIGN_MASK))
		else $error("pointer not loaded");
	AST_PTR_RO: assert property (!ptr_update.load |=> $stable(ptr_reg))
		else $error("pointer changed without update");
	AST_PTR_LOW: assert property (ptr_reg[3:0] == 4'h0)
		else $error("pointer low bits not zero");
	AST_IRQ_GATE: assert property (irq |-> $past(enable_reg[`BIT_MASTER_GATE])
		&& $past(|(intr_status & enable_reg & `EN_SOURCE_MASK)))
		else $error("irq without enabled source and master");
	AST_SET_ONE: assert property (s_set_wr |=>
		(($past(wr_ones) & `EN_DEFINED_MASK) & ~enable_reg) == 32'h00000000
		&& (($past(enable_reg) & ~enable_reg) == 32'h00000000))
		else $error("enable set write wrong");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");

endmodule

`default_nettype wire

// File: rtl/usb_host_regs_defs.svh
`ifndef USB_HOST_REGS_DEFS_SVH
`define USB_HOST_REGS_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_INT_ENABLE      8'h10
`define OFS_INT_EN_CLEAR    8'h14
`define OFS_SHARED_BASE     8'h18
`define OFS_PERIODIC_PTR    8'h1c

// ----------------------------------------------------------------
// Enable register field positions
// ----------------------------------------------------------------
`define BIT_MASTER_GATE     31
`define BIT_OWNERSHIP       30
`define BIT_ROOT_HUB_CHANGE 6
`define BIT_FRAME_OVERFLOW  5
`define BIT_UNRECOVERABLE   4
`define BIT_RESUME_DETECT   3
`define BIT_FRAME_START     2
`define BIT_DONE_WRITEBACK  1
`define BIT_SCHED_OVERRUN   0

// ----------------------------------------------------------------
// Masks and reset values
// ----------------------------------------------------------------
`define EN_DEFINED_MASK     32'hc000007f
`define EN_SOURCE_MASK      32'h4000007f
`define BASE_ALIGN_MASK     32'hffffff00
`define PTR_ALIGN_MASK      32'hfffffff0
`define EN_RESET            32'h00000000
`define BASE_RESET          32'h00000000
`define PTR_RESET           32'h00000000

// ----------------------------------------------------------------
// AXI response codes
// ----------------------------------------------------------------
`define RESP_OKAY           2'b00
`define RESP_SLVERR         2'b10

`endif

// File: rtl/usb_host_regs_pkg.sv
package usb_host_regs_pkg;

	// Register selected by an address
	typedef enum logic [2:0] {
		SEL_NONE   = 3'h0,
		SEL_ENABLE = 3'h1,
		SEL_CLEAR  = 3'h2,
		SEL_BASE   = 3'h3,
		SEL_PTR    = 3'h4
	} reg_sel_e;

	// Write path states, Gray from WAIT to EXEC to RESP
	typedef enum logic [1:0] {
		WR_WAIT = 2'b00,
		WR_EXEC = 2'b01,
		WR_RESP = 2'b11
	} wr_state_e;

	// Captured write request
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] data;
		logic [3:0]  strb;
	} wr_req_s;

	// Periodic pointer update from list processing
	typedef struct packed {
		logic        load;
		logic [31:0] addr;
	} ptr_update_s;

endpackage

// File: tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "usb_host_regs_defs.svh"

module tb_top
	import usb_host_regs_pkg::*;
;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic        clk_sys;                // System clock
	logic        rst;                    // Synchronous reset
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, irq;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, intr_status, exp;
	logic [31:0] interrupt_enable_register, shared_comm_area;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	ptr_update_s ptr_update;             // Pointer load from list logic
	int          fail_count, n_compared, cycles, i, bitn;

	usb_host_intr_regs usb_host_intr_regs_inst (.clk_sys(clk_sys), .rst(rst),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.intr_status(intr_status), .ptr_update(ptr_update),
		.interrupt_enable_register(interrupt_enable_register),
		.shared_comm_area(shared_comm_area), .irq(irq));

	// ----------------------------------------------------------------
	// Clock and hang guard
	// ----------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// Cut the run short if a handshake never completes
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fail_count++;
			report_and_stop();
		end
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		n_compared++;
		if (got !== want) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, want);
		end
	endtask

	// One write; readies sampled mid-cycle, released after the taking edge
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] er);
		logic aw_hit, w_hit, aw_done, w_done, b_hit;
		logic [1:0] resp;
		@(posedge clk_sys);
		s_axi_awvalid <= 1'b1;
		s_axi_awaddr  <= a;
		s_axi_wvalid  <= 1'b1;
		s_axi_wdata   <= d;
		s_axi_wstrb   <= s;
		s_axi_bready  <= 1'b1;
		aw_done = 1'b0;
		w_done = 1'b0;
		while (!(aw_done && w_done)) begin
			@(negedge clk_sys);
			aw_hit = s_axi_awvalid && s_axi_awready;
			w_hit = s_axi_wvalid && s_axi_wready;
			@(posedge clk_sys);
			if (aw_hit) begin
				s_axi_awvalid <= 1'b0;
				aw_done = 1'b1;
			end
			if (w_hit) begin
				s_axi_wvalid <= 1'b0;
				w_done = 1'b1;
			end
		end
		do begin
			@(negedge clk_sys);
			b_hit = s_axi_bvalid;
			resp = s_axi_bresp;
			@(posedge clk_sys);
		end while (b_hit !== 1'b1);
		s_axi_bready <= 1'b0;
		chk({30'h0, resp}, {30'h0, er});
	endtask

	// One read, data sampled mid-cycle in the cycle where rvalid and rready meet
	task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic hit;
		logic [31:0] data;
		logic [1:0] resp;
		@(posedge clk_sys);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr  <= a;
		s_axi_rready  <= 1'b1;
		do begin
			@(negedge clk_sys);
			hit = s_axi_arready;
			@(posedge clk_sys);
		end while (hit !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do begin
			@(negedge clk_sys);
			hit = s_axi_rvalid;
			data = s_axi_rdata;
			resp = s_axi_rresp;
			@(posedge clk_sys);
		end while (hit !== 1'b1);
		s_axi_rready <= 1'b0;
		chk(data, ed);
		chk({30'h0, resp}, {30'h0, er});
	endtask

	// Change status, let the registered request settle, compare it
	task automatic irq_chk(input logic [31:0] st, input logic want);
		@(posedge clk_sys);
		intr_status <= st;
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		chk({31'h0, irq}, {31'h0, want});
	endtask

	// Counts, verdict and end of run
	task automatic report_and_stop();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		{fail_count, n_compared, cycles} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		intr_status = '0;
		ptr_update = '0;
		rst = 1'b1;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		// Every register starts at zero
		axi_read(`OFS_INT_ENABLE, `EN_RESET, `RESP_OKAY);
		axi_read(`OFS_INT_EN_CLEAR, `EN_RESET, `RESP_OKAY);
		axi_read(`OFS_SHARED_BASE, `BASE_RESET, `RESP_OKAY);
		axi_read(`OFS_PERIODIC_PTR, `PTR_RESET, `RESP_OKAY);
		$display("test reset_values done");
		// Set all enables, zero write leaves them, then clear one at a time
		axi_write(`OFS_INT_ENABLE, `EN_DEFINED_MASK, 4'hf, `RESP_OKAY);
		axi_write(`OFS_INT_ENABLE, 32'h0, 4'hf, `RESP_OKAY);
		exp = `EN_DEFINED_MASK;
		axi_read(`OFS_INT_ENABLE, exp, `RESP_OKAY);
		for (i = 0; i < 9; i++) begin
			bitn = (i < 7) ? i : i + 23;
			exp[bitn] = 1'b0;
			axi_write(`OFS_INT_EN_CLEAR, 32'h1 << bitn, 4'hf, `RESP_OKAY);
			axi_read(`OFS_INT_EN_CLEAR, exp, `RESP_OKAY);
			chk(interrupt_enable_register, exp);
		end
		// Only the strobed low byte of a clear write counts
		axi_write(`OFS_INT_ENABLE, `EN_DEFINED_MASK, 4'hf, `RESP_OKAY);
		axi_write(`OFS_INT_EN_CLEAR, `EN_DEFINED_MASK, 4'h1, `RESP_OKAY);
		axi_read(`OFS_INT_EN_CLEAR, 32'hc0000000, `RESP_OKAY);
		$display("test enable_clear done");
		// Base register keeps its low byte at zero
		axi_write(`OFS_SHARED_BASE, 32'h123456ff, 4'hf, `RESP_OKAY);
		axi_read(`OFS_SHARED_BASE, 32'h12345600, `RESP_OKAY);
		axi_write(`OFS_SHARED_BASE, 32'hffffffff, 4'h8, `RESP_OKAY);
		axi_read(`OFS_SHARED_BASE, 32'hff345600, `RESP_OKAY);
		chk(shared_comm_area, 32'hff345600);
		$display("test shared_base done");
		// Pointer loads from the controller only, low nibble reads zero
		@(posedge clk_sys);
		ptr_update <= {1'b1, 32'habcdef5f};
		@(posedge clk_sys);
		ptr_update <= {1'b0, 32'h11111111};
		axi_read(`OFS_PERIODIC_PTR, 32'habcdef50, `RESP_OKAY);
		axi_write(`OFS_PERIODIC_PTR, 32'h0, 4'hf, `RESP_OKAY);
		axi_read(`OFS_PERIODIC_PTR, 32'habcdef50, `RESP_OKAY);
		$display("test periodic_ptr done");
		// Unmapped words answer with an error and read zero
		for (i = 0; i < 2; i++) begin
			axi_write(i ? 8'h20 : 8'h0c, 32'h1, 4'hf, `RESP_SLVERR);
			axi_read(i ? 8'h20 : 8'h0c, 32'h0, `RESP_SLVERR);
		end
		$display("test unmapped done");
		// Request needs status, enable and the master gate together
		axi_write(`OFS_INT_EN_CLEAR, 32'h80000000, 4'hf, `RESP_OKAY);
		axi_write(`OFS_INT_ENABLE, 32'h00000001, 4'hf, `RESP_OKAY);
		irq_chk(32'h00000001, 1'b0);
		axi_write(`OFS_INT_ENABLE, 32'h80000000, 4'hf, `RESP_OKAY);
		irq_chk(32'h00000001, 1'b1);
		irq_chk(32'h00000002, 1'b0);
		irq_chk(32'h40000000, 1'b1);
		axi_write(`OFS_INT_EN_CLEAR, 32'h40000000, 4'hf, `RESP_OKAY);
		irq_chk(32'h40000000, 1'b0);
		$display("test irq done");
		report_and_stop();
	end

endmodule

`default_nettype wire
